// ### pwmwg_core.sv
// pwm waveform core: apb registers, shadow loading, three counters, six event-driven channels
//
// Operation
// - counting and waveforms use only the shadow copies of period and compare.
// - by default both shadows load when a pwm period completes.
// - with immediate load set, a written period or compare enters its shadow at once.
// - immediate load overrides every other loading mode of that channel.
// - up count with new period below count runs to 0xffff, wraps, continues.
// - new period above count: counter keeps counting until equal, ending the period.
// - center load in up-down mode loads compare at the period point.
// - zero, period, up compare and down compare events exist per counting type.
// - up match is equality while counting up, down match while counting down.
// - complementary pairs use both comparators on the shared counter.
// - each event applies no change, low, high or toggle from action registers.
// - up count priority: period, odd compare, even compare, zero.
// - down count priority: zero, odd down compare, even down compare, period.
// - up-down ranks per direction as the fixed five-entry orders below.
// - pair mode bit 0 runs both channels independently.
// - pair mode bit 1 forces the odd channel to invert the even one.
// - independent pulses go on to masking, brake, polarity, then output enable.
// - complementary pulses pair, then dead-time, then the four output stages.
// - counters run up, down or up-down; type and period set boundaries.
// - in complementary mode the even channel also uses the odd comparator.
`timescale 1ns/100ps
`default_nettype none

module pwmwg_core
  import pwmwg_pkg::*;
(
  input  wire logic                i_clk,      // core clock, 100 MHz
  input  wire logic                i_resetn,   // asynchronous reset, active low
  input  wire logic [PWMWG_AW-1:0] i_paddr,    // apb byte address
  input  wire logic                i_psel,     // apb select
  input  wire logic                i_penable,  // apb access phase
  input  wire logic                i_pwrite,   // apb direction, high for write
  input  wire logic [31:0]         i_pwdata,   // apb write data
  input  wire logic [3:0]          i_pstrb,    // apb byte strobes
  output logic      [31:0]         o_prdata,   // apb read data, from flops
  output logic                     o_pready,   // apb ready, always high
  output logic                     o_pslverr,  // apb error for unmapped or read-only write
  output logic [PWMWG_NCH-1:0]     o_wave      // channel waveforms toward the output stages
);

  localparam int unsigned NCH = PWMWG_NCH;
  localparam int unsigned NP  = PWMWG_NPAIR;

  logic [31:0]          load_ctrl_r;
  logic [31:0]          mode_ctrl_r;
  logic [31:0]          wact_a_r;
  logic [31:0]          wact_b_r;
  logic [NP-1:0][15:0]  period_r;
  logic [NP-1:0][15:0]  pshadow_r;
  logic [NP-1:0][15:0]  cnt_r;
  logic [NCH-1:0][15:0] compare_r;
  logic [NCH-1:0][15:0] cshadow_r;
  logic [NP-1:0]        dir_r;
  logic [NP-1:0]        run;
  logic [NP-1:0]        comp;
  logic [NP-1:0]        is_up;
  logic [NP-1:0]        is_dn;
  logic [NP-1:0]        is_ud;
  logic [NP-1:0]        zero;
  logic [NP-1:0]        eq_p;
  logic [NP-1:0]        eff_up;
  logic [NP-1:0]        pend;
  logic [NP-1:0]        center;
  logic [NP-1:0]        wr_period;
  logic [NCH-1:0]       wr_cmp;
  logic [NCH-1:0]       wave_r;
  pwmwg_evt_t [NCH-1:0] evt;
  logic                 acc;
  logic                 wr_en;
  logic                 wr_hit;
  logic                 rd_hit;
  logic [31:0]          rd_data;

  // byte-strobe merge of a write into an existing word
  function automatic logic [31:0] pwmwg_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        res[8*b +: 8] = nw[8*b +: 8];
    end
    return res;
  endfunction

  // first listed event whose action is not "no change" decides the new level
  function automatic logic pwmwg_apply(input logic cur, input logic [4:0] ev,
                                       input logic [9:0] act);
    logic       done;
    logic       res;
    logic [1:0] a;
    done = 1'b0;
    res  = cur;
    a    = ACT_NONE;
    for (int i = 0; i < 5; i++)
    begin
      a = act[2*i +: 2];
      if (!done && ev[i] && (a != ACT_NONE))
      begin
        done = 1'b1;
        case (a)
          ACT_LOW:    res = 1'b0;
          ACT_HIGH:   res = 1'b1;
          ACT_TOGGLE: res = ~cur;
          default:    res = cur;
        endcase
      end
    end
    return res;
  endfunction

  // apb: zero wait states, so every access ends at its first access-phase edge
  assign acc      = i_psel & i_penable;
  assign wr_en    = acc & i_pwrite;
  assign o_pready = 1'b1;
  assign o_pslverr = acc & (i_pwrite ? ~wr_hit : ~rd_hit);

  // write decode; status and shadow words are read only and answer writes with an error
  always_comb
  begin
    wr_hit    = (i_paddr == ADDR_LOAD_CTRL) || (i_paddr == ADDR_MODE_CTRL) ||
                (i_paddr == ADDR_WACT_A) || (i_paddr == ADDR_WACT_B);
    wr_period = '0;
    wr_cmp    = '0;
    for (int k = 0; k < NP; k++)
    begin
      if (i_paddr == ADDR_PERIOD0 + 8'(4*k))
      begin
        wr_period[k] = wr_en;
        wr_hit       = 1'b1;
      end
    end
    for (int n = 0; n < NCH; n++)
    begin
      if (i_paddr == ADDR_COMPARE0 + 8'(4*n))
      begin
        wr_cmp[n] = wr_en;
        wr_hit    = 1'b1;
      end
    end
  end

  // read mux; shadows and counts are readable so software can see what hardware acts on
  always_comb
  begin
    rd_data = '0;
    rd_hit  = 1'b1;
    case (i_paddr)
      ADDR_LOAD_CTRL: rd_data = load_ctrl_r;
      ADDR_MODE_CTRL: rd_data = mode_ctrl_r;
      ADDR_WACT_A:    rd_data = wact_a_r;
      ADDR_WACT_B:    rd_data = wact_b_r;
      default:        rd_hit  = 1'b0;
    endcase
    for (int k = 0; k < NP; k++)
    begin
      if (i_paddr == ADDR_PERIOD0 + 8'(4*k))
      begin
        rd_hit  = 1'b1;
        rd_data = {16'h0000, period_r[k]};
      end
      if (i_paddr == ADDR_COUNT0 + 8'(4*k))
      begin
        rd_hit  = 1'b1;
        rd_data = {15'h0000, dir_r[k], cnt_r[k]};
      end
      if (i_paddr == ADDR_PSHADOW0 + 8'(4*k))
      begin
        rd_hit  = 1'b1;
        rd_data = {16'h0000, pshadow_r[k]};
      end
    end
    for (int n = 0; n < NCH; n++)
    begin
      if (i_paddr == ADDR_COMPARE0 + 8'(4*n))
      begin
        rd_hit  = 1'b1;
        rd_data = {16'h0000, compare_r[n]};
      end
      if (i_paddr == ADDR_CSHADOW0 + 8'(4*n))
      begin
        rd_hit  = 1'b1;
        rd_data = {16'h0000, cshadow_r[n]};
      end
    end
  end

  // read data is captured in the setup cycle and held through the access phase
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_prdata <= REG_RST;
    else if (i_psel && !i_penable && !i_pwrite)
      o_prdata <= rd_data;
  end

  // software-visible control words; hardware acts on these directly, with no shadow copies
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      load_ctrl_r <= REG_RST;
      mode_ctrl_r <= REG_RST;
      wact_a_r    <= REG_RST;
      wact_b_r    <= REG_RST;
    end
    else if (wr_en)
    begin
      if (i_paddr == ADDR_LOAD_CTRL)
        load_ctrl_r <= pwmwg_merge(load_ctrl_r, i_pwdata, i_pstrb);
      if (i_paddr == ADDR_MODE_CTRL)
        mode_ctrl_r <= pwmwg_merge(mode_ctrl_r, i_pwdata, i_pstrb);
      if (i_paddr == ADDR_WACT_A)
        wact_a_r <= pwmwg_merge(wact_a_r, i_pwdata, i_pstrb);
      if (i_paddr == ADDR_WACT_B)
        wact_b_r <= pwmwg_merge(wact_b_r, i_pwdata, i_pstrb);
    end
  end

  // per pair: counter, boundaries and period shadow
  for (genvar k = 0; k < NP; k++)
  begin : g_pair
    logic [31:0] pmerge;
    logic [15:0] pnew;
    // merge into a whole word first; only the low half is stored
    assign pmerge   = pwmwg_merge({16'h0000, period_r[k]}, i_pwdata, i_pstrb);
    assign pnew     = pmerge[15:0];
    assign run[k]   = mode_ctrl_r[RUN_LSB + k];
    assign comp[k]  = mode_ctrl_r[MODE_LSB + k];
    assign is_dn[k] = (mode_ctrl_r[TYPE_LSB + 2*k +: 2] == CT_DOWN);
    assign is_ud[k] = (mode_ctrl_r[TYPE_LSB + 2*k +: 2] == CT_UPDOWN);
    assign is_up[k] = ~is_dn[k] & ~is_ud[k];   // the spare code behaves as up
    assign zero[k]  = (cnt_r[k] == CNT_ZERO);
    assign eq_p[k]  = (cnt_r[k] == pshadow_r[k]);
    // zero belongs to the rising half and the period point to the falling half
    assign eff_up[k] = is_ud[k] ? (zero[k] | (~eq_p[k] & dir_r[k])) : is_up[k];
    assign pend[k]   = run[k] & (is_ud[k] ? (zero[k] & ~dir_r[k]) :
                                 is_dn[k] ? zero[k] : eq_p[k]);
    assign center[k] = run[k] & is_ud[k] & eq_p[k] & dir_r[k];

    // period register as written by software
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
      if (!i_resetn)
        period_r[k] <= CNT_ZERO;
      else if (wr_period[k])
        period_r[k] <= pnew;
    end

    // period shadow; the even channel's immediate bit governs the shared counter
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
      if (!i_resetn)
        pshadow_r[k] <= CNT_ZERO;
      else if (load_ctrl_r[IMM_LSB + 2*k])
      begin
        if (wr_period[k])
          pshadow_r[k] <= pnew;
      end
      else if (!run[k] || pend[k])
        pshadow_r[k] <= period_r[k];
    end

    // counter; a period lowered below an up count is reached again only after the 16-bit wrap
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
      if (!i_resetn)
      begin
        cnt_r[k] <= CNT_ZERO;
        dir_r[k] <= 1'b1;
      end
      else if (!run[k])
      begin
        cnt_r[k] <= is_dn[k] ? pshadow_r[k] : CNT_ZERO;
        dir_r[k] <= 1'b1;
      end
      else if (is_dn[k])
        cnt_r[k] <= zero[k] ? pshadow_r[k] : cnt_r[k] - 16'h0001;
      else if (is_ud[k])
      begin
        if (dir_r[k])
        begin
          if (eq_p[k])
          begin
            dir_r[k] <= 1'b0;
            if (!zero[k])
              cnt_r[k] <= cnt_r[k] - 16'h0001;
          end
          else
            cnt_r[k] <= cnt_r[k] + 16'h0001;
        end
        else if (zero[k])
        begin
          dir_r[k] <= 1'b1;
          if (!eq_p[k])
            cnt_r[k] <= cnt_r[k] + 16'h0001;
        end
        else
          cnt_r[k] <= cnt_r[k] - 16'h0001;
      end
      else
        cnt_r[k] <= eq_p[k] ? CNT_ZERO : cnt_r[k] + 16'h0001;
    end
  end

  // per channel: compare shadow, events and waveform level
  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    localparam int unsigned K  = c / 2;
    localparam int unsigned OD = c | 1;
    localparam int unsigned EV = c - (c % 2);
    logic [31:0] cmerge;
    logic [15:0] cnew;
    logic        mu;
    logic        md;
    logic        nu;
    logic        nd;
    logic [1:0]  a_mu;
    logic [1:0]  a_md;
    logic [1:0]  a_nu;
    logic [1:0]  a_nd;
    logic [1:0]  a_z;
    logic [1:0]  a_p;
    logic [4:0]  ev;
    logic [9:0]  act;

    assign cmerge = pwmwg_merge({16'h0000, compare_r[c]}, i_pwdata, i_pstrb);
    assign cnew   = cmerge[15:0];
    assign evt[c].zero = zero[K];
    assign evt[c].prd  = eq_p[K];
    assign evt[c].compare_match_rising = (cnt_r[K] == cshadow_r[c]) & eff_up[K];
    assign evt[c].compare_match_falling = (cnt_r[K] == cshadow_r[c]) & ~eff_up[K];
    assign a_z  = wact_a_r[ACT_ZERO_LSB + 2*c +: 2];
    assign a_p  = wact_a_r[ACT_PRD_LSB + 2*c +: 2];

    // odd comparator ranks above even; the even channel borrows it when paired
    if (c % 2 == 0)
    begin : g_even
      assign nu   = evt[c].compare_match_rising;
      assign nd   = evt[c].compare_match_falling;
      assign a_nu = wact_b_r[ACT_COMPARE_MATCH_RISING_LSB + 2*c +: 2];
      assign a_nd = wact_b_r[ACT_COMPARE_MATCH_FALLING_LSB + 2*c +: 2];
      assign mu   = comp[K] & evt[OD].compare_match_rising;
      assign md   = comp[K] & evt[OD].compare_match_falling;
      assign a_mu = wact_b_r[ACT_COMPARE_MATCH_RISING_LSB + 2*OD +: 2];
      assign a_md = wact_b_r[ACT_COMPARE_MATCH_FALLING_LSB + 2*OD +: 2];
    end
    else
    begin : g_odd
      assign nu   = 1'b0;
      assign nd   = 1'b0;
      assign a_nu = ACT_NONE;
      assign a_nd = ACT_NONE;
      assign mu   = evt[c].compare_match_rising;
      assign md   = evt[c].compare_match_falling;
      assign a_mu = wact_b_r[ACT_COMPARE_MATCH_RISING_LSB + 2*c +: 2];
      assign a_md = wact_b_r[ACT_COMPARE_MATCH_FALLING_LSB + 2*c +: 2];
    end

    // priority order, slot 0 highest
    always_comb
    begin
      if (is_dn[K])
      begin
        ev  = {1'b0, evt[c].prd, nd, md, evt[c].zero};
        act = {ACT_NONE, a_p, a_nd, a_md, a_z};
      end
      else if (is_ud[K] && eff_up[K])
      begin
        ev  = {nd, md, evt[c].zero, nu, mu};
        act = {a_nd, a_md, a_z, a_nu, a_mu};
      end
      else if (is_ud[K])
      begin
        ev  = {nu, mu, evt[c].prd, nd, md};
        act = {a_nu, a_mu, a_p, a_nd, a_md};
      end
      else
      begin
        ev  = {1'b0, evt[c].zero, nu, mu, evt[c].prd};
        act = {ACT_NONE, a_z, a_nu, a_mu, a_p};
      end
    end

    // compare register as written by software
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
      if (!i_resetn)
        compare_r[c] <= CNT_ZERO;
      else if (wr_cmp[c])
        compare_r[c] <= cnew;
    end

    // compare shadow; while stopped it tracks the register so a start uses fresh values
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
      if (!i_resetn)
        cshadow_r[c] <= CNT_ZERO;
      else if (load_ctrl_r[IMM_LSB + c])
      begin
        if (wr_cmp[c])
          cshadow_r[c] <= cnew;
      end
      else if (!run[K])
        cshadow_r[c] <= compare_r[c];
      else if (load_ctrl_r[CLD_LSB + c] && is_ud[K])
      begin
        if (center[K])
          cshadow_r[c] <= compare_r[c];
      end
      else if (pend[K])
        cshadow_r[c] <= compare_r[c];
    end

    // waveform level holds while its counter is stopped
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
      if (!i_resetn)
        wave_r[c] <= 1'b0;
      else if (run[K])
        wave_r[c] <= pwmwg_apply(wave_r[c], ev, act);
    end

    // complementary pairing; mask, brake, polarity and enable follow outside, in that order
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
      if (!i_resetn)
        o_wave[c] <= 1'b0;
      else if ((c % 2 == 1) && comp[K])
        o_wave[c] <= ~wave_r[EV];
      else
        o_wave[c] <= wave_r[c];
    end
  end

  // checks on pair 0 and channels 0/1
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  a_shadow_hold_mid: assert property (run[0] && !load_ctrl_r[IMM_LSB] &&
    !load_ctrl_r[CLD_LSB] && !pend[0] |=> $stable(cshadow_r[0]))
    else $error("compare shadow changed inside a period");
  a_period_end_load: assert property (run[0] && !load_ctrl_r[IMM_LSB] &&
    !load_ctrl_r[CLD_LSB] && pend[0] |=> cshadow_r[0] == $past(compare_r[0]))
    else $error("compare shadow not loaded at period end");
  a_imm_load_now: assert property (load_ctrl_r[IMM_LSB] && wr_cmp[0] && i_pstrb == 4'hf
    |=> cshadow_r[0] == $past(i_pwdata[15:0]))
    else $error("immediate compare load missed");
  a_imm_blocks_other: assert property (load_ctrl_r[IMM_LSB] && !wr_cmp[0]
    |=> $stable(cshadow_r[0]))
    else $error("shadow changed without write in immediate mode");
  a_up_wraps_max: assert property (run[0] && is_up[0] && cnt_r[0] == CNT_MAX &&
    !eq_p[0] ##1 is_up[0] |-> cnt_r[0] == CNT_ZERO)
    else $error("up counter did not wrap to zero");
  a_up_period_end: assert property (run[0] && is_up[0] && eq_p[0] ##1 run[0]
    |-> cnt_r[0] == CNT_ZERO)
    else $error("up counter passed the period");
  a_center_load: assert property (center[0] && load_ctrl_r[CLD_LSB] &&
    !load_ctrl_r[IMM_LSB] |=> cshadow_r[0] == $past(compare_r[0]))
    else $error("center load missed");
  a_comp_inverse: assert property (comp[0] ##1 comp[0] |-> o_wave[1] != o_wave[0])
    else $error("odd channel not inverse of even");
  a_indep_own: assert property (!comp[0] |=> o_wave[1] == $past(wave_r[1]))
    else $error("odd channel not independent");
  a_up_prd_first: assert property (run[0] && is_up[0] && eq_p[0] &&
    wact_a_r[ACT_PRD_LSB +: 2] == ACT_HIGH |=> wave_r[0])
    else $error("period action lost its priority");

  c_up_wrap: cover property (run[0] && is_up[0] && cnt_r[0] == CNT_MAX ##1 zero[0]);
  c_center_load: cover property (center[0] && load_ctrl_r[CLD_LSB]);
  c_comp_edge: cover property (comp[0] && $rose(o_wave[0]));

endmodule

`default_nettype wire

// ### pwmwg_pkg.sv
// package: map, field layout, encodings and carriers of the buffered pwm waveform core
package pwmwg_pkg;

  // structure of the block: three counters, each shared by an even/odd channel pair
  localparam int unsigned PWMWG_NCH   = 6;
  localparam int unsigned PWMWG_NPAIR = 3;
  localparam int unsigned PWMWG_AW    = 8;

  // register byte addresses on the apb port
  localparam logic [7:0] ADDR_LOAD_CTRL = 8'h00;  // load_control_reg
  localparam logic [7:0] ADDR_MODE_CTRL = 8'h04;  // mode_control_reg
  localparam logic [7:0] ADDR_WACT_A    = 8'h08;  // wave_action_ctrl_a
  localparam logic [7:0] ADDR_WACT_B    = 8'h0c;  // wave_action_ctrl_b
  localparam logic [7:0] ADDR_PERIOD0   = 8'h10;  // period of pair k at +4*k
  localparam logic [7:0] ADDR_COMPARE0  = 8'h20;  // compare_value of channel n at +4*n
  localparam logic [7:0] ADDR_COUNT0    = 8'h40;  // counter_value and direction, read only
  localparam logic [7:0] ADDR_PSHADOW0  = 8'h50;  // period_shadow of pair k, read only
  localparam logic [7:0] ADDR_CSHADOW0  = 8'h60;  // compare_shadow of channel n, read only

  // field positions
  localparam int unsigned CLD_LSB      = 0;   // center_load_enable, one bit per channel
  localparam int unsigned IMM_LSB      = 16;  // immediate_load_enable, one bit per channel
  localparam int unsigned TYPE_LSB     = 0;   // counter type, two bits per pair
  localparam int unsigned RUN_LSB      = 8;   // counter run, one bit per pair
  localparam int unsigned MODE_LSB     = 24;  // pair_output_mode, one bit per pair
  localparam int unsigned ACT_ZERO_LSB = 0;   // wave_action_ctrl_a, two bits per channel
  localparam int unsigned ACT_PRD_LSB  = 16;  // wave_action_ctrl_a, two bits per channel
  localparam int unsigned ACT_COMPARE_MATCH_RISING_LSB = 0;   // wave_action_ctrl_b, two bits per channel
  localparam int unsigned ACT_COMPARE_MATCH_FALLING_LSB = 16;  // wave_action_ctrl_b, two bits per channel
  localparam int unsigned DIR_BIT      = 16;  // direction flag in the count status word

  // reset and counter limits
  localparam logic [31:0] REG_RST  = 32'h0000_0000;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_MAX  = 16'hffff;

  typedef enum logic [1:0] {
    CT_UP     = 2'b00,
    CT_DOWN   = 2'b01,
    CT_UPDOWN = 2'b10
  } pwmwg_ctype_t;

  typedef enum logic [1:0] {
    ACT_NONE   = 2'b00,
    ACT_LOW    = 2'b01,
    ACT_HIGH   = 2'b10,
    ACT_TOGGLE = 2'b11
  } pwmwg_act_t;

  // event points seen by one channel in one cycle
  typedef struct packed {
    logic zero;
    logic prd;
    logic compare_match_rising;
    logic compare_match_falling;
  } pwmwg_evt_t;

endpackage

// ### pwmwg_stage.sv
// switching stage model: times channel 0 pulses and watches the pair 0 switches
`timescale 1ns/100ps
`default_nettype none
module pwmwg_stage
  import pwmwg_pkg::*;
(
  input  wire logic                 i_clk,   // core clock
  input  wire logic [PWMWG_NCH-1:0] i_wave,  // channel levels into the stages
  input  wire logic                 i_comp,  // pair 0 is driven as a complementary pair
  output logic      [15:0]          o_prd,   // cycles between the last two rises of ch0
  output logic      [15:0]          o_hi,    // length of the last high pulse of ch0
  output logic      [15:0]          o_bad    // cycles in complementary mode where both pair switches agreed on a held ch0 level
);
  logic [15:0] run_r;
  logic [15:0] hi_r;
  logic        last_r;

  // counters start cleared; the stage has no reset pin of its own
  initial
  begin
    run_r = 16'h0000;
    hi_r = 16'h0000;
    last_r = 1'b0;
    o_prd = 16'h0000;
    o_hi = 16'h0000;
    o_bad = 16'h0000;
  end

  // the stage sees each level at the clock; a one-cycle lag of the odd side is tolerated
  always @(posedge i_clk)
  begin
    last_r <= i_wave[0];
    run_r <= (i_wave[0] && !last_r) ? 16'h0001 : run_r + 16'h0001;
    hi_r <= i_wave[0] ? hi_r + 16'h0001 : 16'h0000;
    if (i_wave[0] && !last_r)
      o_prd <= run_r;
    if (!i_wave[0] && last_r)
      o_hi <= hi_r;
    if (i_comp && i_wave[1] === i_wave[0] && i_wave[0] === last_r)
      o_bad <= o_bad + 16'h0001;
  end
endmodule
`default_nettype wire

// ### test_pwmwg_core.sv
// self-checking testbench of the buffered pwm waveform core
`timescale 1ns/100ps
`default_nettype none
module test_pwmwg_core
  import pwmwg_pkg::*;
;
  logic        clk;
  logic        resetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  wave;
  logic        comp;
  logic [15:0] prd_m;
  logic [15:0] hi_m;
  logic [15:0] bad_m;
  logic [33:0] q[$];
  logic [33:0] x;
  logic [31:0] rnd;
  int          seed;
  int          err_count;
  int          cmp_count;

  pwmwg_core DUT (
    .i_clk(clk), .i_resetn(resetn), .i_paddr(paddr), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_pwdata(pwdata), .i_pstrb(4'hf),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_wave(wave)
  );

  pwmwg_stage stage (
    .i_clk(clk), .i_wave(wave), .i_comp(comp), .o_prd(prd_m), .o_hi(hi_m), .o_bad(bad_m)
  );

  always #5 clk = ~clk;

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count = cmp_count + 1;
    if (s !== e)
    begin
      err_count = err_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, s, e);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // one apb transfer; the expected answer is noted before the bus is driven
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic e);
    q.push_back({~w, e, d});
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // no wait count assumed; only the watchdog ends a stuck access
    while (pready !== 1'b1)
      @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b0, d, 1'b0);
  endtask

  // stop, set the action words, restart; stopping first keeps shadows in step
  task automatic run(input logic [31:0] a, input logic [31:0] b, input logic [31:0] m);
    wr(ADDR_MODE_CTRL, 32'h0);
    wr(ADDR_WACT_A, a);
    wr(ADDR_WACT_B, b);
    wr(ADDR_MODE_CTRL, m);
    repeat (4) @(posedge clk);
  endtask

  task automatic pulse(input logic [31:0] a, input logic [31:0] b, input logic [31:0] m,
                       input logic [15:0] p, input logic [15:0] h);
    run(a, b, m);
    repeat (30) @(posedge clk);
    chk({16'h0, prd_m}, {16'h0, p});
    chk({16'h0, hi_m}, {16'h0, h});
  endtask

  task automatic lvl(input logic [31:0] a, input logic [31:0] b, input logic [31:0] m,
                     input logic e);
    run(a, b, m);
    repeat (20) @(posedge clk);
    repeat (4)
    begin
      @(posedge clk);
      #1;
      chk({31'h0, wave[0]}, {31'h0, e});
    end
  endtask

  // monitor: each completed access takes the oldest note and compares it
  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'b1)
    begin
      x = q.pop_front();
      chk({31'h0, pslverr}, {31'h0, x[32]});
      if (x[33])
        chk(prdata, x[31:0]);
    end
  end

  // watchdog: the sequence needs well under two thousand cycles
  initial
  begin
    #100000;
    err_count = err_count + 1;
    finish_test();
  end

  initial
  begin
    clk = 1'b0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    comp = 1'b0;
    seed = 32'h617134d7;
    err_count = 0;
    cmp_count = 0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    chk({26'h0, wave}, 32'h0);
    chk({31'h0, pready}, 32'h1);
    rd(ADDR_MODE_CTRL, REG_RST);
    rd(ADDR_LOAD_CTRL, REG_RST);
    apb(8'h80, 1'b0, 32'h0, 1'b1);
    apb(ADDR_COUNT0, 1'b1, 32'h5, 1'b1);
    $display("test reset done");
    // pulse timing per counter type and action code
    wr(ADDR_PERIOD0, 32'h3);
    wr(ADDR_COMPARE0, 32'h1);
    pulse(32'h0000_0002, 32'h0000_0001, 32'h100, 16'h4, 16'h1);
    pulse(32'h0002_0000, 32'h0001_0000, 32'h101, 16'h4, 16'h2);
    wr(ADDR_LOAD_CTRL, 32'h0000_0001);
    pulse(32'h0000_0000, 32'h0002_0001, 32'h102, 16'h6, 16'h2);
    pulse(32'h0000_0003, 32'h0000_0000, 32'h100, 16'h8, 16'h4);
    $display("test pulses done");
    // coinciding events: period beats compare going up, zero beats compare going down
    wr(ADDR_COMPARE0, 32'h3);
    lvl(32'h0002_0000, 32'h0000_0001, 32'h100, 1'b1);
    wr(ADDR_COMPARE0, 32'h0);
    lvl(32'h0000_0001, 32'h0002_0000, 32'h101, 1'b0);
    $display("test priority done");
    // shadows: period waits for the boundary, immediate compare does not
    wr(ADDR_MODE_CTRL, 32'h0);
    wr(ADDR_PERIOD0, 32'h100);
    wr(ADDR_MODE_CTRL, 32'h100);
    wr(ADDR_PERIOD0, 32'h80);
    rd(ADDR_PSHADOW0, 32'h100);
    wr(ADDR_LOAD_CTRL, 32'h0001_0001);
    rnd = $random(seed) & 32'hffff;
    wr(ADDR_COMPARE0, rnd);
    wr(ADDR_COMPARE0 + 8'h04, rnd);
    rd(ADDR_CSHADOW0, rnd);
    rd(ADDR_CSHADOW0 + 8'h04, 32'h0);
    $display("test shadows done");
    // complementary pair 0: the odd side is the inverse of the even one
    wr(ADDR_MODE_CTRL, 32'h0);
    wr(ADDR_LOAD_CTRL, 32'h0);
    wr(ADDR_PERIOD0, 32'h3);
    wr(ADDR_COMPARE0, 32'h1);
    // odd comparator at 2 sets the even channel high: high for counts 3, 0 and 1
    wr(ADDR_COMPARE0 + 8'h04, 32'h2);
    run(32'h0000_0002, 32'h0000_0009, 32'h0100_0100);
    comp <= 1'b1;
    repeat (30) @(posedge clk);
    chk({16'h0, bad_m}, 32'h0);
    chk({16'h0, prd_m}, 32'h4);
    chk({16'h0, hi_m}, 32'h3);
    $display("test complementary done");
    finish_test();
  end
endmodule
`default_nettype wire
